// >>> verilog/osw_map.svh
`ifndef OSW_MAP_SVH
`define OSW_MAP_SVH
// Register byte offsets
`define OSW_CTRL_OFS      12'h000
`define OSW_STAT_OFS      12'h004
`define OSW_OSC_WAIT_OFS  12'h008
`define OSW_PLL_WAIT_OFS  12'h00c
`define OSW_PLL_RATIO_OFS 12'h010
`define OSW_IRQ_EN_OFS    12'h014
`define OSW_IRQ_ST_OFS    12'h018
`define OSW_IRQ_CLR_OFS   12'h01c
`define OSW_LPM_OFS       12'h020
// Control fields
`define OSW_MAIN_EN_BIT   1
`define OSW_SUB_EN_BIT    3
`define OSW_PLL_EN_BIT    4
// Wait register fields: main [7:0], sub [15:8]; pll wait [7:0], input select bit 8
`define OSW_PLL_SEL_BIT   8
// Interrupt bits
`define OSW_IRQ_FREQ      0
`define OSW_IRQ_PLL       1
`define OSW_IRQ_SUB       2
`define OSW_IRQ_MAIN      3
// Reset values
`define OSW_WAIT_RST      8'h10
`define OSW_RATIO_RST     16'h1311
`endif

// >>> verilog/osw_pkg.sv
package osw_pkg;
    typedef enum logic [1:0] {
        OSW_STOPPED = 2'b00,
        OSW_WAITING = 2'b01,
        OSW_READY   = 2'b11
    } osw_state_type;
endpackage : osw_pkg

// >>> verilog/osw_top.sv
`timescale 1ns/10ps
`include "osw_map.svh"
// Behaviour
// - VCO frequency is reference times M times N
// - Output clock is VCO divided by M
// - During wait, clocks gated, only counter runs
// - Elapsed wait marks oscillator ready
// - Main wait from register, fast RC counted
// - Sub wait from register, slow RC counted
// - PLL register holds select and wait
// - Setting enable bit starts the wait
// - RTC wake rewaits all but sub
// - Stop wake rewaits every source
// - PLL reported ready only after wait or software reset
// - No wait after software reset
// - Flag follows counter, not oscillator
// - Frequency anomaly raises interrupt
// - PLL wait end raises interrupt
// - Sub wait end raises interrupt
// - Main wait end raises interrupt
// - Enable register gates each source
// - Read-only status shows pending sources
// - Write-only clear register clears sources
// - Ready bit 0 waiting/stopped, 1 stable
module osw_top (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Pins from outside
    input  wire logic        FAST_RC_TICK,
    input  wire logic        SLOW_RC_TICK,
    input  wire logic        FREQ_ANOMALY,
    input  wire logic        WAKE_RTC,
    input  wire logic        WAKE_STOP,
    input  wire logic        SOFT_RESET,
    // Clock system outputs
    output logic             MAIN_CLK_GATE,
    output logic             SUB_CLK_GATE,
    output logic             PLL_CLK_GATE,
    output logic             PLL_INPUT_SEL,
    output logic      [4:0]  PLL_REF_DIV,
    output logic      [4:0]  PLL_OUT_DIV,
    output logic      [5:0]  PLL_FB_MUL,
    output logic      [10:0] PLL_VCO_RATIO,
    output logic             CLK_IRQ
);
    // Synchronisers for pins
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [5:0] sync_d;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
            sync_d <= 6'h00;
        end else begin
            sync_a <= {SOFT_RESET, WAKE_STOP, WAKE_RTC, FREQ_ANOMALY, SLOW_RC_TICK,
                       FAST_RC_TICK};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end
    // Edge pulses of synchronised inputs
    wire [5:0] rise = sync_b & ~sync_d;
    wire fast_tick  = rise[0];
    wire slow_tick  = rise[1];
    wire anomaly    = rise[2];
    wire wake_rtc   = rise[3];
    wire wake_stop  = rise[4];
    wire soft_rst   = rise[5];

    // Registers
    logic [7:0]  ctrl;
    logic [15:0] osc_wait_time_reg;
    logic [8:0]  pll_wait_time_reg;
    logic [15:0] pll_ratio;
    logic [3:0]  clk_irq_enable_reg;
    logic [3:0]  clk_irq_status_reg;
    logic        freq_detect_en;

    // AHB address phase capture
    logic        dp_write;
    logic        dp_read;
    logic [11:0] dp_addr;
    wire take = HSEL & HREADY & HTRANS[1];
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 12'h000;
        end else begin
            dp_write <= take & HWRITE;
            dp_read  <= take & ~HWRITE;
            dp_addr  <= HADDR;
        end
    end
    // Zero-wait slave, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // Write strobes
    wire wr_ctrl  = dp_write & (dp_addr == `OSW_CTRL_OFS);
    wire wr_oscw  = dp_write & (dp_addr == `OSW_OSC_WAIT_OFS);
    wire wr_pllw  = dp_write & (dp_addr == `OSW_PLL_WAIT_OFS);
    wire wr_ratio = dp_write & (dp_addr == `OSW_PLL_RATIO_OFS);
    wire wr_ien   = dp_write & (dp_addr == `OSW_IRQ_EN_OFS);
    wire wr_clr   = dp_write & (dp_addr == `OSW_IRQ_CLR_OFS);
    wire wr_lpm   = dp_write & (dp_addr == `OSW_LPM_OFS);

    // Enable bits; a rising enable starts a wait
    wire main_en = ctrl[`OSW_MAIN_EN_BIT];
    wire sub_en  = ctrl[`OSW_SUB_EN_BIT];
    wire pll_en  = ctrl[`OSW_PLL_EN_BIT];
    wire [7:0] new_ctrl = HWDATA[7:0] & 8'h1a;
    wire main_go = wr_ctrl & new_ctrl[`OSW_MAIN_EN_BIT] & ~main_en;
    wire sub_go  = wr_ctrl & new_ctrl[`OSW_SUB_EN_BIT] & ~sub_en;
    wire pll_go  = wr_ctrl & new_ctrl[`OSW_PLL_EN_BIT] & ~pll_en;
    // RTC wake rewaits all but sub; stop wake rewaits all
    wire main_rew = (wake_rtc | wake_stop) & main_en;
    wire pll_rew  = (wake_rtc | wake_stop) & pll_en;
    wire sub_rew  = wake_stop & sub_en;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl               <= 8'h00;
            osc_wait_time_reg  <= {`OSW_WAIT_RST, `OSW_WAIT_RST};
            pll_wait_time_reg  <= {1'b0, `OSW_WAIT_RST};
            pll_ratio          <= `OSW_RATIO_RST;
            clk_irq_enable_reg <= 4'h0;
            freq_detect_en     <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl <= new_ctrl;
            if (wr_oscw)
                osc_wait_time_reg <= HWDATA[15:0];
            if (wr_pllw)
                pll_wait_time_reg <= HWDATA[8:0];
            if (wr_ratio)
                pll_ratio <= HWDATA[15:0];
            if (wr_ien)
                clk_irq_enable_reg <= HWDATA[3:0];
            if (wr_lpm)
                freq_detect_en <= HWDATA[0];
        end
    end

    // One wait counter per source
    osw_pkg::osw_state_type st [3];
    logic [7:0]  cnt [3];
    logic [2:0]  done;
    wire [2:0] go   = {pll_go | pll_rew, sub_go | sub_rew, main_go | main_rew};
    wire [2:0] en   = {pll_en, sub_en, main_en};
    wire [2:0] tick = {fast_tick, slow_tick, fast_tick};
    wire [7:0] lim [3];
    assign lim[0] = osc_wait_time_reg[7:0];
    assign lim[1] = osc_wait_time_reg[15:8];
    assign lim[2] = pll_wait_time_reg[7:0];
    // Writing an enable back to 0 stops that source at once
    wire [2:0] wr_off = wr_ctrl ? ~{new_ctrl[`OSW_PLL_EN_BIT], new_ctrl[`OSW_SUB_EN_BIT],
                                    new_ctrl[`OSW_MAIN_EN_BIT]} : 3'b000;

    // Wait sequencer; flag follows the count only
    for (genvar i = 0; i < 3; i++) begin : g_wait
        always_ff @(posedge REF_CLK) begin
            if (RESET) begin
                st[i]   <= osw_pkg::OSW_STOPPED;
                cnt[i]  <= 8'h00;
                done[i] <= 1'b0;
            end else begin
                done[i] <= 1'b0;
                if (wr_off[i]) begin
                    st[i] <= osw_pkg::OSW_STOPPED;
                end else if (soft_rst && en[i]) begin
                    st[i] <= osw_pkg::OSW_READY;
                end else if (go[i]) begin
                    st[i]  <= osw_pkg::OSW_WAITING;
                    cnt[i] <= 8'h00;
                end else begin
                    case (st[i])
                        osw_pkg::OSW_WAITING: begin
                            if (tick[i]) begin
                                if (cnt[i] + 8'h01 >= lim[i]) begin
                                    st[i]   <= osw_pkg::OSW_READY;
                                    done[i] <= 1'b1;
                                end else begin
                                    cnt[i] <= cnt[i] + 8'h01;
                                end
                            end
                        end
                        osw_pkg::OSW_STOPPED, osw_pkg::OSW_READY: ;
                        default: st[i] <= osw_pkg::OSW_STOPPED;
                    endcase
                end
            end
        end
    end
    // Ready flags and gated clocks
    wire main_osc_ready_flag = (st[0] == osw_pkg::OSW_READY);
    wire sub_osc_ready_flag  = (st[1] == osw_pkg::OSW_READY);
    wire pll_ready_flag      = (st[2] == osw_pkg::OSW_READY);
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            MAIN_CLK_GATE <= 1'b0;
            SUB_CLK_GATE  <= 1'b0;
            PLL_CLK_GATE  <= 1'b0;
        end else begin
            MAIN_CLK_GATE <= main_osc_ready_flag;
            SUB_CLK_GATE  <= sub_osc_ready_flag;
            PLL_CLK_GATE  <= pll_ready_flag;
        end
    end

    // PLL ratio: K [4:0], M [9:5] minus one style kept as plain values
    function automatic logic [4:0] nz5(input logic [4:0] v);
        nz5 = (v == 5'h00) ? 5'h01 : v;
    endfunction : nz5
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            PLL_INPUT_SEL <= 1'b0;
            PLL_REF_DIV   <= 5'h01;
            PLL_OUT_DIV   <= 5'h01;
            PLL_FB_MUL    <= 6'h01;
            PLL_VCO_RATIO <= 11'h001;
        end else begin
            PLL_INPUT_SEL <= pll_wait_time_reg[`OSW_PLL_SEL_BIT];
            PLL_REF_DIV   <= nz5(pll_ratio[4:0]);
            PLL_OUT_DIV   <= nz5(pll_ratio[9:5]);
            PLL_FB_MUL    <= (pll_ratio[15:10] == 6'h00) ? 6'h01 : pll_ratio[15:10];
            PLL_VCO_RATIO <= 11'(nz5(pll_ratio[9:5]) * PLL_FB_MUL);
        end
    end

    // Interrupt status; set wins over clear
    wire [3:0] irq_set = {done[0], done[1], done[2], anomaly & freq_detect_en};
    wire [3:0] irq_clr = wr_clr ? HWDATA[3:0] : 4'h0;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            clk_irq_status_reg <= 4'h0;
            CLK_IRQ            <= 1'b0;
        end else begin
            clk_irq_status_reg <= irq_set | (clk_irq_status_reg & ~irq_clr);
            CLK_IRQ            <= |(clk_irq_status_reg & clk_irq_enable_reg);
        end
    end

    // Read mux
    wire [31:0] stat_word = {27'h0, pll_ready_flag, sub_osc_ready_flag, 1'b0,
                             main_osc_ready_flag, 1'b0};
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            HRDATA <= 32'h0;
        end else if (take & ~HWRITE) begin
            case (HADDR)
                `OSW_CTRL_OFS:      HRDATA <= {24'h0, ctrl};
                `OSW_STAT_OFS:      HRDATA <= stat_word;
                `OSW_OSC_WAIT_OFS:  HRDATA <= {16'h0, osc_wait_time_reg};
                `OSW_PLL_WAIT_OFS:  HRDATA <= {23'h0, pll_wait_time_reg};
                `OSW_PLL_RATIO_OFS: HRDATA <= {16'h0, pll_ratio};
                `OSW_IRQ_EN_OFS:    HRDATA <= {28'h0, clk_irq_enable_reg};
                `OSW_IRQ_ST_OFS:    HRDATA <= {28'h0, clk_irq_status_reg};
                `OSW_LPM_OFS:       HRDATA <= {31'h0, freq_detect_en};
                default:            HRDATA <= 32'h0;
            endcase
        end
    end

    // Checks
    chk_ready_after_done: assert property (@(posedge REF_CLK) disable iff (RESET)
        done[0] |-> st[0] == osw_pkg::OSW_READY) else $error("main not ready at done");
    chk_main_irq_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        done[0] |=> clk_irq_status_reg[3]) else $error("main irq missing");
    chk_sub_irq_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        done[1] |=> clk_irq_status_reg[2]) else $error("sub irq missing");
    chk_pll_irq_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        done[2] |=> clk_irq_status_reg[1]) else $error("pll irq missing");
    chk_start_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
        main_go & ~soft_rst |=> st[0] == osw_pkg::OSW_WAITING) else $error("no wait");
    chk_gate_off_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
        st[2] == osw_pkg::OSW_WAITING ##1 st[2] == osw_pkg::OSW_WAITING |-> !PLL_CLK_GATE)
        else $error("pll clock during wait");
    chk_irq_masked: assert property (@(posedge REF_CLK) disable iff (RESET)
        (clk_irq_status_reg & clk_irq_enable_reg) == 4'h0 |=> !CLK_IRQ)
        else $error("irq not masked");
    chk_clear_works: assert property (@(posedge REF_CLK) disable iff (RESET)
        wr_clr & HWDATA[0] & ~irq_set[0] |=> !clk_irq_status_reg[0])
        else $error("clear failed");
    chk_soft_no_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
        soft_rst & main_en & ~wr_off[0] |=> main_osc_ready_flag) else $error("wait after soft");

    // A foreign tick must never finish a wait; soft reset is the only shortcut
    chk_main_fast_only: assert property (@(posedge REF_CLK) disable iff (RESET)
        st[0] == osw_pkg::OSW_WAITING && !fast_tick && !soft_rst
        |=> st[0] != osw_pkg::OSW_READY) else $error("main wait ended without fast tick");
    chk_sub_slow_only: assert property (@(posedge REF_CLK) disable iff (RESET)
        st[1] == osw_pkg::OSW_WAITING && !slow_tick && !soft_rst
        |=> st[1] != osw_pkg::OSW_READY) else $error("sub wait ended without slow tick");
    chk_pll_fast_only: assert property (@(posedge REF_CLK) disable iff (RESET)
        st[2] == osw_pkg::OSW_WAITING && !fast_tick && !soft_rst
        |=> st[2] != osw_pkg::OSW_READY) else $error("pll wait ended without fast tick");
    // A fresh enable never reports ready straight away
    chk_pll_wait_first: assert property (@(posedge REF_CLK) disable iff (RESET)
        pll_go |=> !pll_ready_flag) else $error("pll ready without wait");
    // Done pulse only when a count really ends, whatever the oscillator does
    chk_done_from_count: assert property (@(posedge REF_CLK) disable iff (RESET)
        done[1] |-> $past(st[1]) == osw_pkg::OSW_WAITING && $past(slow_tick))
        else $error("sub done without count");
    // Gates follow the ready flags one register later
    chk_gate_follows: assert property (@(posedge REF_CLK) disable iff (RESET)
        main_osc_ready_flag |=> MAIN_CLK_GATE) else $error("main gate missing");
    chk_gate_withheld: assert property (@(posedge REF_CLK) disable iff (RESET)
        !sub_osc_ready_flag |=> !SUB_CLK_GATE) else $error("sub clock while not ready");
    // RTC wake leaves the running sub oscillator alone; stop wake rewaits
    chk_rtc_keeps_sub: assert property (@(posedge REF_CLK) disable iff (RESET)
        wake_rtc && !wake_stop && !wr_ctrl && sub_osc_ready_flag |=> sub_osc_ready_flag)
        else $error("rtc wake dropped sub");
    chk_stop_rewaits: assert property (@(posedge REF_CLK) disable iff (RESET)
        wake_stop && main_en && !wr_ctrl && !soft_rst |=> st[0] == osw_pkg::OSW_WAITING)
        else $error("stop wake skipped main wait");
    // Anomaly sets its bit only while supervision is on
    chk_freq_irq_set: assert property (@(posedge REF_CLK) disable iff (RESET)
        anomaly && freq_detect_en |=> clk_irq_status_reg[0]) else $error("freq irq missing");
    chk_freq_irq_off: assert property (@(posedge REF_CLK) disable iff (RESET)
        !(anomaly && freq_detect_en) && !clk_irq_status_reg[0] |=> !clk_irq_status_reg[0])
        else $error("freq irq without anomaly");
    // Status moves only by an event or a clear
    chk_status_holds: assert property (@(posedge REF_CLK) disable iff (RESET)
        irq_set == 4'h0 && !wr_clr |=> $stable(clk_irq_status_reg))
        else $error("status changed by itself");
    // Enabled pending source must reach the line
    chk_irq_follows: assert property (@(posedge REF_CLK) disable iff (RESET)
        (clk_irq_status_reg & clk_irq_enable_reg) != 4'h0 |=> CLK_IRQ) else $error("irq lost");
endmodule : osw_top

// >>> verif/osw_top_tb_top.sv
`timescale 1ns/10ps
module osw_top_tb_top;
    // Bench-side signals
    logic        ref_clk;
    logic        reset;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [5:0]  pins;
    logic        main_gate;
    logic        sub_gate;
    logic        pll_gate;
    logic        pll_sel;
    logic [4:0]  ref_div;
    logic [4:0]  out_div;
    logic [5:0]  fb_mul;
    logic [10:0] vco_ratio;
    logic        clk_irq;
    int          fail_count;
    int          total_checks;
    // Pin slots: fast tick, slow tick, anomaly, rtc wake, stop wake, soft reset
    localparam int fast = 0, slow = 1, anom = 2, rtc = 3, stp = 4, srst = 5;

    // Slave's own ready closes the bus loop
    osw_top i_dut (
        .REF_CLK(ref_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .FAST_RC_TICK(pins[fast]), .SLOW_RC_TICK(pins[slow]), .FREQ_ANOMALY(pins[anom]),
        .WAKE_RTC(pins[rtc]), .WAKE_STOP(pins[stp]), .SOFT_RESET(pins[srst]),
        .MAIN_CLK_GATE(main_gate), .SUB_CLK_GATE(sub_gate), .PLL_CLK_GATE(pll_gate),
        .PLL_INPUT_SEL(pll_sel), .PLL_REF_DIV(ref_div), .PLL_OUT_DIV(out_div),
        .PLL_FB_MUL(fb_mul), .PLL_VCO_RATIO(vco_ratio), .CLK_IRQ(clk_irq));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One single AHB transfer; entered right after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        // Only ready ends a wait; a hang is left to the watchdog
        do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp(q, e);
    endtask : rd

    // Pins pass a synchroniser, so each pulse is held two cycles
    task automatic tick(input int idx, input int n);
        repeat (n) begin
            pins[idx] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            pins[idx] <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
    endtask : tick

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        fail_count = 0;
        total_checks = 0;
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 12'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pins = 6'h0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h1010);
        rd(12'h00c, 32'h10);
        rd(12'h010, 32'h1311);
        rd(12'h030, 32'h0);
        // K=2, M=3, N=5
        wr(12'h010, 32'h1462);
        repeat (3) @(posedge ref_clk);
        cmp(32'(ref_div), 32'h2);
        cmp(32'(out_div), 32'h3);
        cmp(32'(fb_mul), 32'h5);
        cmp(32'(vco_ratio), 32'hf);
        wr(12'h008, 32'h0203);
        wr(12'h00c, 32'h104);
        rd(12'h00c, 32'h104);
        cmp(32'(pll_sel), 32'h1);
        wr(12'h014, 32'hf);
        // Main wait counts only fast ticks
        wr(12'h000, 32'h2);
        rd(12'h000, 32'h2);
        tick(slow, 3);
        rd(12'h004, 32'h0);
        cmp(32'(main_gate), 32'h0);
        tick(fast, 2);
        rd(12'h004, 32'h0);
        tick(fast, 1);
        rd(12'h004, 32'h2);
        cmp(32'(main_gate), 32'h1);
        rd(12'h018, 32'h8);
        cmp(32'(hresp), 32'h0);
        cmp(32'(clk_irq), 32'h1);
        wr(12'h018, 32'h0);
        rd(12'h018, 32'h8);
        wr(12'h01c, 32'h8);
        rd(12'h018, 32'h0);
        rd(12'h01c, 32'h0);
        cmp(32'(clk_irq), 32'h0);
        // Sub wait counts only slow ticks
        wr(12'h000, 32'ha);
        tick(fast, 3);
        rd(12'h004, 32'h2);
        tick(slow, 1);
        rd(12'h004, 32'h2);
        tick(slow, 1);
        rd(12'h004, 32'ha);
        rd(12'h018, 32'h4);
        cmp(32'(sub_gate), 32'h1);
        wr(12'h01c, 32'h4);
        // PLL ready only after its full wait
        wr(12'h000, 32'h1a);
        tick(fast, 3);
        rd(12'h004, 32'ha);
        cmp(32'(pll_gate), 32'h0);
        tick(fast, 1);
        rd(12'h004, 32'h1a);
        rd(12'h018, 32'h2);
        wr(12'h014, 32'hd);
        repeat (2) @(posedge ref_clk);
        cmp(32'(clk_irq), 32'h0);
        wr(12'h01c, 32'h2);
        // Anomaly counts only while supervision is on
        tick(anom, 1);
        rd(12'h018, 32'h0);
        wr(12'h020, 32'h1);
        tick(anom, 1);
        rd(12'h018, 32'h1);
        cmp(32'(clk_irq), 32'h1);
        wr(12'h01c, 32'h1);
        // Wakes rewait; software reset skips waits
        tick(rtc, 1);
        rd(12'h004, 32'h8);
        tick(fast, 4);
        rd(12'h004, 32'h1a);
        tick(stp, 1);
        rd(12'h004, 32'h0);
        tick(srst, 1);
        rd(12'h004, 32'h1a);
        wr(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        cmp(32'(pll_gate), 32'h0);
        wrap_up();
    end
endmodule : osw_top_tb_top
